// File: inc/relay_matrix_defines.vh
`ifndef RELAY_MATRIX_DEFINES_VH
`define RELAY_MATRIX_DEFINES_VH
// force timeout; 48-bit operands so the cycle product cannot wrap at 32 bits
`define FORCE_TIMEOUT_MIN 48'h0000_0000_0005
`define SEC_PER_MIN 48'h0000_0000_003C
`define CLK_FREQ_HZ 48'h0000_0EE6_B280
`define FORCE_TIMEOUT_CYCLES (`FORCE_TIMEOUT_MIN * `SEC_PER_MIN * `CLK_FREQ_HZ)
`define FORCE_CNT_RESET 48'h0000_0000_0000
`define COIL_OFF 1'h0
`define COIL_ON 1'h1
`endif

// File: design/output_relay_matrix_latch.v
// Overview of operation
// - any internal source can be routed to any output coil through a configurable matrix.
// - each output is driven by the matrix, by a logic function output, or by test forcing.
// - each output has its own latched or non-latched setting.
// - force requests are ignored unless the force enable was set beforehand.
// - each output state reads as one for an energized coil and zero for de-energized.
// - the reported state means coil energization regardless of normally open or closed contacts.
// - latched states are cleared by a release from the enter key or from the setting tool.
// - the release-all-latches command is accepted only while a password session is active.
// - every logic function output is a matrix source automatically.
// - the force flag and all forced outputs clear after a five-minute timeout.
`include "relay_matrix_defines.vh"
`default_nettype none

module output_relay_matrix_latch #(
  parameter NUM_SRC = 16,
  parameter NUM_LOGIC = 8,
  parameter NUM_OUT = 16,
  parameter [47:0] FORCE_TIMEOUT_CYCLES = `FORCE_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // internal signals and logic outputs
  input wire [NUM_SRC-1:0] src_in,
  input wire [NUM_LOGIC-1:0] logic_in,
  // routing configuration, row per output
  input wire [NUM_OUT*(NUM_SRC+NUM_LOGIC)-1:0] matrix_cfg,
  input wire [NUM_OUT-1:0] latch_cfg,
  // operator controls
  input wire enter_key_release,
  input wire tool_release,
  input wire release_all,
  input wire password_ok,
  input wire force_enable_set,
  input wire force_enable_clear,
  input wire force_write,
  input wire [NUM_OUT-1:0] force_value,
  // coils and status
  output wire [NUM_OUT-1:0] coil_out,
  output reg [NUM_OUT-1:0] coil_state_reg,
  output reg force_flag_reg
);

localparam NSEL = NUM_SRC + NUM_LOGIC;

// force control states; the flag is up in every state but the first
localparam [1:0] FORCE_OFF = 2'h0;
localparam [1:0] FORCE_ARMED = 2'h1;
localparam [1:0] FORCE_DRIVING = 2'h2;

////////////////////////////////////////////////////////////////////////////
// one matrix row against the joined source list
function route_hit;
  input [NSEL-1:0] row;
  input [NSEL-1:0] sources;
  begin
    route_hit = |(row & sources);
  end
endfunction

// last cycle of the force window; a limit of zero is not supported
function window_done;
  input [47:0] count;
  input [47:0] limit;
  begin
    window_done = (count >= limit - 48'h0000_0000_0001);
  end
endfunction

// coil energization for one output; forcing overrides routing and latching
function coil_level;
  input forced;
  input forced_bit;
  input latch_bit;
  input routed_bit;
  input held_bit;
  begin
    if (forced) begin
      coil_level = forced_bit;
    end else if (latch_bit) begin
      coil_level = routed_bit | held_bit;
    end else begin
      coil_level = routed_bit;
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// force control
reg [1:0] force_state_reg;
reg [1:0] force_state_next;
reg force_flag_next;
reg [47:0] force_cnt_reg;
reg [47:0] force_cnt_next;
reg [NUM_OUT-1:0] forced_val_reg;
reg [NUM_OUT-1:0] forced_val_next;

// latch and coil paths
reg [NUM_OUT-1:0] latched_reg;
reg [NUM_OUT-1:0] latched_next;
reg [NUM_OUT-1:0] coil_state_next;
reg [NUM_OUT-1:0] routed;
reg [NUM_OUT-1:0] drive;

// matrix and strobes
wire [NSEL-1:0] all_src;
wire release_req;
wire timeout;
wire forcing;
integer i;
integer k;

// logic outputs join the source list without any configuration step
assign all_src = {logic_in, src_in};

// release-all only under an active password session; key and tool releases need none
assign release_req = enter_key_release | tool_release | (release_all & password_ok);

assign timeout = window_done(force_cnt_reg, FORCE_TIMEOUT_CYCLES);
assign forcing = (force_state_reg == FORCE_DRIVING);

////////////////////////////////////////////////////////////////////////////
always @* begin
  for (i = 0; i < NUM_OUT; i = i + 1) begin
    routed[i] = route_hit(matrix_cfg[i*NSEL +: NSEL], all_src);
  end
end

// new activation wins over a release in the same cycle, so no trip is lost
always @* begin
  latched_next = release_req ? {NUM_OUT{`COIL_OFF}} : latched_reg;
  latched_next = latched_next | (routed & latch_cfg);
end

always @* begin
  for (k = 0; k < NUM_OUT; k = k + 1) begin
    drive[k] = coil_level(forcing, forced_val_reg[k], latch_cfg[k],
      routed[k], latched_reg[k]);
  end
end

// coil level is energization, not contact position
assign coil_out = drive;

always @* begin
  coil_state_next = drive;
end

////////////////////////////////////////////////////////////////////////////
// clear beats set, set beats the timeout and restarts the window
always @* begin
  force_state_next = force_state_reg;
  force_cnt_next = force_cnt_reg;
  forced_val_next = forced_val_reg;
  case (force_state_reg)
    FORCE_OFF: begin
      force_cnt_next = `FORCE_CNT_RESET;
      // flag must already be set; a write in the enabling cycle is dropped
      if (force_enable_set && !force_enable_clear) begin
        force_state_next = FORCE_ARMED;
      end
    end
    FORCE_ARMED, FORCE_DRIVING: begin
      if (force_enable_clear) begin
        force_state_next = FORCE_OFF;
        force_cnt_next = `FORCE_CNT_RESET;
      end else if (timeout && !force_enable_set) begin
        force_state_next = FORCE_OFF;
        force_cnt_next = `FORCE_CNT_RESET;
      end else begin
        if (force_enable_set) begin
          force_cnt_next = `FORCE_CNT_RESET;
        end else begin
          force_cnt_next = force_cnt_reg + 48'h0000_0000_0001;
        end
        if (force_write) begin
          force_state_next = FORCE_DRIVING;
          forced_val_next = force_value;
        end
      end
    end
    default: begin
      force_state_next = FORCE_OFF;
      force_cnt_next = `FORCE_CNT_RESET;
    end
  endcase
  force_flag_next = (force_state_next != FORCE_OFF);
end

////////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
  if (reset) begin
    latched_reg <= {NUM_OUT{`COIL_OFF}};
  end else begin
    latched_reg <= latched_next;
  end
end

always @(posedge clk) begin
  if (reset) begin
    coil_state_reg <= {NUM_OUT{`COIL_OFF}};
  end else begin
    coil_state_reg <= coil_state_next;
  end
end

// forcing is dropped by reset as well as by the timeout
always @(posedge clk) begin
  if (reset) begin
    force_state_reg <= FORCE_OFF;
    force_flag_reg <= 1'h0;
    force_cnt_reg <= `FORCE_CNT_RESET;
    forced_val_reg <= {NUM_OUT{`COIL_OFF}};
  end else begin
    force_state_reg <= force_state_next;
    force_flag_reg <= force_flag_next;
    force_cnt_reg <= force_cnt_next;
    forced_val_reg <= forced_val_next;
  end
end

endmodule // output_relay_matrix_latch

`default_nettype wire

// File: verif/relay_matrix_checker.sv
`default_nettype none
module relay_matrix_checker #(parameter int FORCE_TIMEOUT_CYCLES = 20) (
  // clock and force controls
  input wire logic clk,
  input wire logic reset,
  input wire logic force_enable_set,
  input wire logic force_enable_clear,
  input wire logic force_write,
  input wire logic [15:0] force_value,
  // coils and flag
  input wire logic [15:0] coil_out,
  input wire logic [15:0] coil_state_reg,
  input wire logic force_flag_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = FORCE_TIMEOUT_CYCLES + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_flag_cause: assert property ($rose(force_flag_reg) |-> $past(force_enable_set))
    else $error("flag rose without set");
  a_set_raises: assert property (force_enable_set && !force_enable_clear |=> force_flag_reg)
    else $error("set ignored");
  a_clear_drops: assert property (force_enable_clear |=> !force_flag_reg)
    else $error("clear ignored");
  a_timeout_bound: assert property ($rose(force_flag_reg) |-> ##[1:W] !force_flag_reg)
    else $error("flag outlived timeout");
  a_no_early_drop: assert property ($rose(force_flag_reg) ##0 (!force_enable_clear)[*8]
    |-> force_flag_reg) else $error("flag dropped early");
  a_force_value: assert property (force_flag_reg && force_write && !force_enable_clear
    |=> coil_out == $past(force_value)) else $error("forced value lost");
  a_state_copy: assert property (!$past(reset) |-> coil_state_reg == $past(coil_out))
    else $error("state not a copy");
  a_forced_state: assert property (force_flag_reg && force_write && !force_enable_clear
    |=> ##1 coil_state_reg == $past(force_value, 2)) else $error("forced state lost");
  c_forced: cover property (force_flag_reg && force_write);
  c_cleared: cover property (force_flag_reg && force_enable_clear);
  c_expired: cover property ($fell(force_flag_reg) && !$past(force_enable_clear));
endmodule // relay_matrix_checker
bind output_relay_matrix_latch relay_matrix_checker #(.FORCE_TIMEOUT_CYCLES(FORCE_TIMEOUT_CYCLES))
  u_chk (.clk, .reset, .force_enable_set, .force_enable_clear, .force_write, .force_value,
  .coil_out, .coil_state_reg, .force_flag_reg);
`default_nettype wire

// File: verif/relay_panel_model.sv
`default_nettype none
module relay_panel_model (
  // key press in, coils out
  input wire logic clk,
  input wire logic press,
  input wire logic [15:0] coil_out,
  output logic enter_key_release = 1'b0,
  output logic [15:0] energized
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) enter_key_release <= press;
  assign energized = coil_out; // nc contacts still report the coil
endmodule // relay_panel_model
`default_nettype wire

// File: verif/output_relay_matrix_latch_tb.sv
`default_nettype none
module output_relay_matrix_latch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, tr = 0, ra = 0, pw = 0, fs = 0, fc = 0, fw = 0, press = 0;
  logic [15:0] src = 0, lc = 0, fv = 0;
  logic [7:0] lg = 0;
  logic [383:0] mx = 0;
  wire [15:0] co, cs, en;
  wire ek, ff;
  int fail_count = 0, n_checks = 0, i;
  initial forever #2 clk = ~clk;
  output_relay_matrix_latch #(.FORCE_TIMEOUT_CYCLES(48'h0000_0000_0014)) dut (.clk(clk),
    .reset(reset), .src_in(src), .logic_in(lg), .matrix_cfg(mx), .latch_cfg(lc),
    .enter_key_release(ek), .tool_release(tr), .release_all(ra), .password_ok(pw),
    .force_enable_set(fs), .force_enable_clear(fc), .force_write(fw), .force_value(fv),
    .coil_out(co), .coil_state_reg(cs), .force_flag_reg(ff));
  relay_panel_model u_panel (.clk(clk), .press(press), .coil_out(co), .enter_key_release(ek),
    .energized(en));
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      fail_count++;
    end
  endtask
  // the write waits one edge so that the flag is already up when it is sampled
  task force_on;
    fs = 1;
    cyc(1);
    fs = 0;
    fw = 1;
    cyc(1);
    fw = 0;
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    cyc(16);
    reset = 0;
    mx[0] = 1;
    mx[40] = 1;
    src[0] = 1;
    lg[0] = 1;
    cyc(1);
    chk("route", 16'h0003, co);
    src[0] = 0;
    lg[0] = 0;
    lc[0] = 1;
    cyc(1);
    chk("follow", 16'h0000, co);
    // password, tool and key releases in turn; first try lacks the password
    for (i = 0; i < 4; i++) begin
      src[0] = 1;
      cyc(1);
      src[0] = 0;
      cyc(2);
      chk("latch", 16'h0001, co);
      ra = i < 2;
      pw = i == 1;
      tr = i == 2;
      press = i == 3;
      cyc(1);
      ra = 0;
      pw = 0;
      tr = 0;
      press = 0;
      cyc(2);
      chk("release", {15'h0000, i == 0}, co);
    end
    lc = 0;
    fv = 16'h00a5;
    fw = 1;
    cyc(1);
    fw = 0;
    chk("refused", 16'h0000, co);
    force_on;
    chk("forced", 16'h00a5, co);
    cyc(1);
    chk("state", 16'h00a5, cs);
    chk("energized", 16'h00a5, en);
    // window of 20 edges from the set edge; two have passed already
    for (i = 0; i < 30 && ff !== 1'b0; i++) begin
      cyc(1);
    end
    chk("expiry", 16'h0012, i[15:0]);
    chk("timeout", 16'h0000, {ff, co[14:0]});
    force_on;
    fc = 1;
    cyc(1);
    fc = 0;
    chk("clear", 16'h0000, {ff, co[14:0]});
    // reset in mid-run with a latch held and all outputs forced
    lc = 16'h0001;
    src[0] = 1;
    cyc(1);
    src[0] = 0;
    force_on;
    chk("forced again", 16'h00a5, co);
    reset = 1;
    cyc(1);
    reset = 0;
    chk("reset drive", 16'h0000, {ff, co[14:0]});
    cyc(1);
    chk("reset state", 16'h0000, cs);
    src[0] = 1;
    cyc(1);
    src[0] = 0;
    cyc(1);
    chk("relatch", 16'h0001, co);
    give_verdict;
  end
endmodule // output_relay_matrix_latch_tb
`default_nettype wire
